// File: core/lfr_params.svh
// Constants for the lock-limit and position-detect fault response block.
// Assumes a 200 MHz clock and a 32-bit APB register bus.
`ifndef LFR_PARAMS_SVH
`define LFR_PARAMS_SVH

// Register byte offsets
`define LFR_OFF_CTRL      12'h000
`define LFR_OFF_MODE      12'h004
`define LFR_OFF_STATUS    12'h008
`define LFR_OFF_THRESH    12'h00C

// Control register fields
`define LFR_CTRL_CLR      0
`define LFR_CTRL_TMO_EN   1
`define LFR_CTRL_RATE_EN  2

// Mode register fields
`define LFR_MODE_HARD_LSB 0
`define LFR_MODE_SOFT_LSB 4

// Threshold register fields
`define LFR_THR_HARD_LSB  0
`define LFR_THR_SOFT_LSB  12

// Status register bits
`define LFR_ST_HARD       0
`define LFR_ST_SOFT       1
`define LFR_ST_TMO_A      2
`define LFR_ST_TMO_B      3
`define LFR_ST_RATE       4
`define LFR_ST_LATCHED    8
`define LFR_ST_RETRY      9

// Reset values
`define LFR_CTRL_RST      3'h0
`define LFR_MODE_RST      8'h00
`define LFR_THR_RST       24'hFFFFFF

// Timing
`define LFR_CLK_MHZ       200
`define LFR_TMO_MS        500
`define LFR_TMO_CYC       (`LFR_TMO_MS * 1000 * `LFR_CLK_MHZ)
`define LFR_RETRY_MS      1000
`define LFR_RETRY_CYC     (`LFR_RETRY_MS * 1000 * `LFR_CLK_MHZ)

`endif

// File: core/lfr_pkg.sv
// Types for the lock-limit and position-detect fault response block.
// Assumes lfr_params.svh holds the numeric constants.
package lfr_pkg;

   // FET bridge action requested
   typedef enum logic [1:0] {
      LFR_FET_ACTIVE = 2'b00,
      LFR_FET_HIZ    = 2'b01,
      LFR_FET_HS_BRK = 2'b10,
      LFR_FET_LS_BRK = 2'b11
   } lfr_fet_t;

   // Recovery class of a decoded fault
   typedef enum logic [1:0] {
      LFR_REC_NONE   = 2'b00,
      LFR_REC_REPORT = 2'b01,
      LFR_REC_RETRY  = 2'b10,
      LFR_REC_LATCH  = 2'b11
   } lfr_rec_t;

   // Response state
   typedef enum logic [1:0] {
      LFR_ST_RUN   = 2'b00,
      LFR_ST_LATCH = 2'b01,
      LFR_ST_RETRY = 2'b10
   } lfr_state_t;

endpackage

// File: core/lfr_mode_decode.sv
// Decoder from a four-bit lock-limit action code to action and class.
// Assumes code is a stable register value on the same clock.
`timescale 1ns/1ps
module lfr_mode_decode
   import lfr_pkg::*;
(
   // Code in
   input  wire logic [3:0] code,
   // Decoded action
   output lfr_fet_t        fet,
   output lfr_rec_t        rec
);

   always_comb begin
      fet = LFR_FET_ACTIVE;
      rec = LFR_REC_NONE;
      if (code[3]) begin
         // 1xx1 is silent; other 1xxx codes only report
         rec = code[0] ? LFR_REC_NONE : LFR_REC_REPORT;    // see RQ4
      end else begin
         rec = code[2] ? LFR_REC_RETRY : LFR_REC_LATCH;    // see RQ1 RQ3
         unique case (code[1:0])
            2'b10:   fet = LFR_FET_HS_BRK;                  // see RQ2 RQ3
            2'b11:   fet = LFR_FET_LS_BRK;                  // see RQ2 RQ3
            default: fet = LFR_FET_HIZ;                     // see RQ1 RQ3
         endcase
      end
   end

endmodule // lfr_mode_decode

// File: core/lfr_fault_resp.sv
// Fault response for hard/soft lock current limits and position detect.
// Assumes sense and phase inputs are asynchronous and APB on clk.
//
// Behaviour
// RQ1: Hard lock code 0000: Hi-Z, report, latch until clear-fault.
// RQ2: Codes 0010/0011: high/low-side brake, report, latch until cleared.
// RQ3: Codes 0100/0110/0111: Hi-Z/HS/LS brake, report, auto retry.
// RQ4: Code 1000 reports only; codes 1xx1 do nothing.
// RQ5: Flag timeout when a detect ramp phase exceeds 500 ms.
// RQ6: Timeout enable 0 ignores it; 1 gives Hi-Z, report, retry.
// RQ7: Early detect pulse with enable 1: Hi-Z, report, retry.
// RQ8: Soft lock limit decodes its code like the hard limit.
// RQ9: Host writes one to clear-fault to release a latched fault.
`timescale 1ns/1ps
`include "lfr_params.svh"
module lfr_fault_resp
   import lfr_pkg::*;
#(
   parameter int unsigned TMO_CYCLES   = `LFR_TMO_CYC,
   parameter int unsigned RETRY_CYCLES = `LFR_RETRY_CYC
) (
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        rst_n,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // Sensing, asynchronous
   input  wire logic [11:0] sense_amp_output,
   input  wire logic        ramp_up_active,
   input  wire logic        ramp_down_active,
   input  wire logic        pulse_early,
   // Bridge and fault pin
   output lfr_fet_t         fet_action,
   output logic             fault_indicator_n
);

   // Two-flop synchronisers; multi-bit sense assumed slow-moving
   // A word torn mid-change lasts one cycle and is judged again next cycle
   logic [14:0] sync1_q;
   logic [14:0] sync2_q;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sync1_q <= 15'h0000;
         sync2_q <= 15'h0000;
      end else begin
         sync1_q <= {pulse_early, ramp_down_active, ramp_up_active,
                     sense_amp_output};
         sync2_q <= sync1_q;
      end
   end

   wire [11:0] sense_s = sync2_q[11:0];
   wire        up_s    = sync2_q[12];
   wire        down_s  = sync2_q[13];
   wire        early_s = sync2_q[14];

   // Software registers
   logic [1:0]  ctrl_q;
   logic [7:0]  mode_q;
   logic [23:0] thr_q;
   logic [4:0]  flags_q;
   lfr_state_t  state_q;
   lfr_state_t  state_d;
   lfr_fet_t    fet_q;
   lfr_fet_t    fet_d;
   logic        nflt_q;
   logic        nflt_d;
   logic [31:0] prdata_q;
   logic        pready_q;
   logic        pslverr_q;
   logic [31:0] retry_cnt_q;
   logic [31:0] tmo_cnt_q;
   logic        ramp_prev_q;

   wire [3:0]  hard_lock_action_code = mode_q[`LFR_MODE_HARD_LSB +: 4];
   wire [3:0]  soft_lock_action_code = mode_q[`LFR_MODE_SOFT_LSB +: 4];
   wire [11:0] hard_lock_current_threshold = thr_q[`LFR_THR_HARD_LSB +: 12];
   wire [11:0] soft_lock_current_threshold = thr_q[`LFR_THR_SOFT_LSB +: 12];
   wire position_timeout_fault_enable = ctrl_q[0];
   wire pulse_rate_fault_enable       = ctrl_q[1];

   // APB decode; one wait state, unmapped addresses flag an error
   wire acc      = psel && penable && !pready_q;
   // Writes land at the edge that completes the transfer, so a register
   // never changes before the master sees its answer
   wire commit   = psel && penable && pready_q;
   wire hit_ctrl = paddr == `LFR_OFF_CTRL;
   wire hit_mode = paddr == `LFR_OFF_MODE;
   wire hit_stat = paddr == `LFR_OFF_STATUS;
   wire hit_thr  = paddr == `LFR_OFF_THRESH;
   wire hit_any  = hit_ctrl || hit_mode || hit_stat || hit_thr;
   wire wr       = commit && pwrite && hit_any;
   wire clear_fault_cmd = wr && hit_ctrl && pwdata[`LFR_CTRL_CLR];

   // Fault conditions
   wire hard_lock_fault  = sense_s > hard_lock_current_threshold;
   wire soft_lock_fault  = sense_s > soft_lock_current_threshold;
   wire ramp_s           = up_s || down_s;
   wire tmo_hit          = ramp_s && (tmo_cnt_q >= TMO_CYCLES - 1); // see RQ5
   wire position_detect_timeout_a = tmo_hit && up_s;
   wire position_detect_timeout_b = tmo_hit && down_s && !up_s;
   wire tmo_fault = tmo_hit && position_timeout_fault_enable;   // see RQ6
   wire position_pulse_rate_fault = early_s && pulse_rate_fault_enable;
   // see RQ7

   // Decoders for both limits
   lfr_fet_t hard_fet;
   lfr_fet_t soft_fet;
   lfr_rec_t hard_rec;
   lfr_rec_t soft_rec;

   lfr_mode_decode u_hard_dec (
      .code (hard_lock_action_code),
      .fet  (hard_fet),
      .rec  (hard_rec)
   );

   lfr_mode_decode u_soft_dec (               // see RQ8
      .code (soft_lock_action_code),
      .fet  (soft_fet),
      .rec  (soft_rec)
   );

   wire hard_on = hard_lock_fault && hard_rec != LFR_REC_NONE; // see RQ4
   wire soft_on = soft_lock_fault && soft_rec != LFR_REC_NONE; // see RQ8
   wire hard_latch = hard_lock_fault && hard_rec == LFR_REC_LATCH;
   wire soft_latch = soft_lock_fault && soft_rec == LFR_REC_LATCH;
   wire hard_retry = hard_lock_fault && hard_rec == LFR_REC_RETRY;
   wire soft_retry = soft_lock_fault && soft_rec == LFR_REC_RETRY;
   wire any_latch  = hard_latch || soft_latch;                // see RQ1 RQ2
   wire any_retry  = hard_retry || soft_retry || tmo_fault ||
                     position_pulse_rate_fault;               // see RQ3 RQ6
   wire any_report = hard_on || soft_on;
   wire cond_live  = any_latch || any_retry;

   // Action for a new fault: latched wins, then lock codes, then Hi-Z
   lfr_fet_t new_fet;
   assign new_fet = hard_latch ? hard_fet :
                    soft_latch ? soft_fet :
                    hard_retry ? hard_fet :
                    soft_retry ? soft_fet : LFR_FET_HIZ;

   // Status bits follow the enables, so a masked fault leaves no trace
   wire [4:0] flag_set = {position_pulse_rate_fault,
                          position_detect_timeout_b &&
                             position_timeout_fault_enable,
                          position_detect_timeout_a &&
                             position_timeout_fault_enable,
                          soft_on, hard_on};

   // Response state machine
   always_comb begin
      state_d = state_q;
      fet_d   = fet_q;
      unique case (state_q)
         LFR_ST_RUN: begin
            fet_d = LFR_FET_ACTIVE;
            if (any_latch) begin
               state_d = LFR_ST_LATCH;
               fet_d   = new_fet;
            end else if (any_retry) begin
               state_d = LFR_ST_RETRY;
               fet_d   = new_fet;
            end
         end
         LFR_ST_LATCH: begin
            // Release only once cleared and the condition is gone
            if (clear_fault_cmd && !cond_live) begin      // see RQ9
               state_d = LFR_ST_RUN;
               fet_d   = LFR_FET_ACTIVE;
            end
         end
         LFR_ST_RETRY: begin
            // A latched fault overrides a pending retry
            if (any_latch) begin
               state_d = LFR_ST_LATCH;                     // see RQ1
               fet_d   = new_fet;
            end else if (retry_cnt_q >= RETRY_CYCLES - 1 && !cond_live) begin
               state_d = LFR_ST_RUN;                       // see RQ3
               fet_d   = LFR_FET_ACTIVE;
            end
         end
         default: begin
            state_d = LFR_ST_RUN;
            fet_d   = LFR_FET_ACTIVE;
         end
      endcase
   end

   // Pin low while any report stands or a fault state is held
   // Report-only codes drop the pin only while their condition stands
   always_comb begin
      nflt_d = !(state_d != LFR_ST_RUN || any_report ||
                 (|flag_set));
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= LFR_ST_RUN;
         fet_q   <= LFR_FET_ACTIVE;
         nflt_q  <= 1'b1;
      end else begin
         state_q <= state_d;
         fet_q   <= fet_d;
         nflt_q  <= nflt_d;
      end
   end

   // Retry timer restarts while any latch or retry condition persists
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         retry_cnt_q <= 32'h00000000;
      end else if (state_q != LFR_ST_RETRY || cond_live) begin
         retry_cnt_q <= 32'h00000000;
      end else if (retry_cnt_q < RETRY_CYCLES - 1) begin
         retry_cnt_q <= retry_cnt_q + 32'h00000001;
      end
   end

   // Ramp phase timer, restarts on each phase edge
   // Switching from ramp-up to ramp-down starts a new phase
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         tmo_cnt_q   <= 32'h00000000;
         ramp_prev_q <= 1'b0;
      end else begin
         ramp_prev_q <= up_s;
         if (!ramp_s || up_s != ramp_prev_q) begin
            tmo_cnt_q <= 32'h00000000;                   // see RQ5
         end else if (tmo_cnt_q < TMO_CYCLES - 1) begin
            tmo_cnt_q <= tmo_cnt_q + 32'h00000001;
         end
      end
   end

   // Sticky status flags; a new set wins over the clear
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         flags_q <= 5'h00;
      end else if (clear_fault_cmd) begin
         flags_q <= flag_set;
      end else begin
         flags_q <= flags_q | flag_set;
      end
   end

   // Control, mode and threshold registers
   // The clear bit is not stored: it acts only in the cycle of its write
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_q <= 2'h0;
         mode_q <= `LFR_MODE_RST;
         thr_q  <= `LFR_THR_RST;
      end else begin
         if (wr && hit_ctrl) begin
            ctrl_q <= {pwdata[`LFR_CTRL_RATE_EN], pwdata[`LFR_CTRL_TMO_EN]};
         end
         if (wr && hit_mode) begin
            mode_q <= pwdata[7:0];
         end
         if (wr && hit_thr) begin
            thr_q <= pwdata[23:0];
         end
      end
   end

   // Read mux
   wire [31:0] rd_ctrl = {29'h0, pulse_rate_fault_enable,
                          position_timeout_fault_enable, 1'b0};
   wire [31:0] rd_mode = {24'h0, mode_q};
   wire [31:0] rd_thr  = {8'h0, thr_q};
   wire [31:0] controller_fault_flags = {22'h0,
                          state_q == LFR_ST_RETRY,
                          state_q == LFR_ST_LATCH,
                          3'h0, flags_q};
   wire [31:0] rd_data = hit_ctrl ? rd_ctrl :
                         hit_mode ? rd_mode :
                         hit_stat ? controller_fault_flags :
                         hit_thr  ? rd_thr  : 32'h00000000;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         prdata_q  <= 32'h00000000;
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
      end else begin
         pready_q  <= acc;
         pslverr_q <= acc && !hit_any;
         if (acc && !pwrite) begin
            prdata_q <= rd_data;
         end
      end
   end

   assign prdata            = prdata_q;
   assign pready            = pready_q;
   assign pslverr           = pslverr_q;
   assign fet_action        = fet_q;
   assign fault_indicator_n = nflt_q;

endmodule // lfr_fault_resp

// File: tb/lfr_fault_resp_checker.sv
// Port-level assertions for the fault response block.
// Assumes it is bound onto lfr_fault_resp with one clock domain.
`timescale 1ns/1ps
module lfr_fault_resp_checker
   import lfr_pkg::*;
(
   // Clock and reset
   input wire logic        clk,
   input wire logic        rst_n,
   // Register bus
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   // Bridge and pin
   input lfr_fet_t         fet_action,
   input wire logic        fault_indicator_n
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   sequence s_acc;
      psel && penable && !pready;
   endsequence
   sequence s_unmap;
      s_acc ##0 !(paddr inside {12'h000, 12'h004, 12'h008, 12'h00C});
   endsequence
   a_one_wait: assert property (s_acc |=> pready)
      else $error("no ready after access");
   a_ready_pulse: assert property (pready |=> !pready)
      else $error("ready longer than one cycle");
   a_setup_quiet: assert property (psel && !penable |-> !pready)
      else $error("ready during setup");
   a_unmap_err: assert property (s_unmap |=> pslverr)
      else $error("no error on unmapped address");
   a_map_ok: assert property (
      s_acc ##0 (paddr inside {12'h000, 12'h004, 12'h008, 12'h00C})
      |=> !pslverr)
      else $error("error on mapped address");
   a_err_ready: assert property (pslverr |-> pready)
      else $error("error without ready");
   a_unmap_zero: assert property (s_unmap ##0 !pwrite |=> prdata == 32'h0)
      else $error("unmapped read not zero");
   a_rdata_hold: assert property (
      !(psel && penable && !pready && !pwrite) |=> $stable(prdata))
      else $error("read data moved without a read");
   a_pin_reports: assert property (
      fet_action != LFR_FET_ACTIVE |-> !fault_indicator_n)
      else $error("action without fault pin");
   a_reset_quiet: assert property (
      $rose(rst_n) |-> fet_action == LFR_FET_ACTIVE && fault_indicator_n)
      else $error("fault state out of reset");
endmodule // lfr_fault_resp_checker

bind lfr_fault_resp lfr_fault_resp_checker chk (
   .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .fet_action(fet_action),
   .fault_indicator_n(fault_indicator_n));

// File: tb/lfr_host_model.sv
// Host side: register bus master issuing clear-fault and reads.
// Assumes a slave that answers with pready on the same clock.
`timescale 1ns/1ps
module lfr_host_model (
   // Clock
   input wire logic         clk,
   // Register bus
   output logic             psel,
   output logic             penable,
   output logic             pwrite,
   output logic      [11:0] paddr,
   output logic      [31:0] pwdata,
   input wire logic  [31:0] prdata,
   input wire logic         pready,
   input wire logic         pslverr
);
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
   end
   task automatic xfer(input logic w, input logic [11:0] a,
                       input logic [31:0] d, output logic [31:0] q,
                       output logic e);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      pwdata <= ~d;
   endtask
   // Clear-fault is a write of one to bit 0 of control
   task automatic clr;
      logic [31:0] q;
      logic e;
      xfer(1'b1, 12'h000, 32'h1, q, e);
   endtask
endmodule // lfr_host_model

// File: tb/tb_top.sv
// Self-checking bench for the fault response block.
// Assumes the host model drives the bus; counts are shortened.
`timescale 1ns/1ps
module tb_top;
   logic        clk = 1'b0, rst_n = 1'b0, ru = 1'b0, rdn = 1'b0;
   logic        pe = 1'b0, psel, penable, pwrite, pready, pslverr;
   logic        pin_n, e;
   logic [11:0] paddr, sense = 12'h000;
   logic [31:0] pwdata, prdata, q;
   logic [1:0]  fet;
   logic [3:0]  a;
   int          n_mismatch = 0, checked = 0, cyc = 0, s, c, k, en;
   always #2.5 clk = ~clk;
   lfr_fault_resp #(.TMO_CYCLES(50), .RETRY_CYCLES(40)) dut (
      .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .sense_amp_output(sense),
      .ramp_up_active(ru), .ramp_down_active(rdn), .pulse_early(pe),
      .fet_action(fet), .fault_indicator_n(pin_n));
   lfr_host_model host (
      .clk(clk), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr));
   // Reference: [3:2] 0 none 1 report 2 retry 3 latch, [1:0] action
   function automatic logic [3:0] ref_act(input int c);
      if (c[3]) return c[0] ? 4'h0 : 4'h4;
      return {(c[2] ? 2'b10 : 2'b11),
              (c[1] ? (c[0] ? 2'b11 : 2'b10) : 2'b01)};
   endfunction
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("wrong value at %0t: %h, expected %h", $time, seen, exp);
      end
   endtask
   task wait_cyc(input int n);
      repeat (n) @(posedge clk);
   endtask
   task wr(input logic [11:0] ad, input logic [31:0] d);
      host.xfer(1'b1, ad, d, q, e);
   endtask
   task give_verdict;
      $display("checks %0d, mismatches %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_mismatch++;
         give_verdict;
      end
   end
   initial begin
      void'($urandom(9102));
      wait_cyc(5);
      rst_n <= 1'b1;
      host.xfer(1'b0, 12'h004, 32'h0, q, e);
      chk(q, 32'h0);
      host.xfer(1'b0, 12'h00C, 32'h0, q, e);
      chk(q, 32'h00FFFFFF);
      host.xfer(1'b0, 12'h010, 32'h0, q, e);
      chk({q[30:0], e}, 32'h1);
      $display("test reset done");
      // Skipped codes 1010, 1100, 1110 have no defined action
      for (s = 0; s < 2; s++) for (c = 0; c < 16; c++)
         if (!(c inside {10, 12, 14})) begin
            a = ref_act(c);
            wr(12'h004, c << (4 * s));
            wr(12'h00C, s ? 32'h00064FFF : 32'h00FFF064);
            sense <= 12'(101 + $urandom_range(3994));
            wait_cyc(6);
            chk(fet, a[1:0]);
            chk(pin_n, a[3:2] == 2'b00);
            host.xfer(1'b0, 12'h008, 32'h0, q, e);
            chk(q[s], a[3:2] != 2'b00);
            chk(q[9:8], {a[3:2] == 2'b10, a[3:2] == 2'b11});
            if (a[3:2] == 2'b11) begin
               host.clr;
               wait_cyc(4);
               chk(fet, a[1:0]);
            end
            sense <= 12'h000;
            wait_cyc(6);
            chk(fet, a[3] ? a[1:0] : 2'b00);
            chk(pin_n, !a[3]);
            wait_cyc(50);
            chk(fet, a[3:2] == 2'b11 ? a[1:0] : 2'b00);
            host.clr;
            wait_cyc(4);
            chk({fet, pin_n}, 3'b001);
         end
      $display("test lock done");
      for (k = 0; k < 3; k++) for (en = 0; en < 2; en++) begin
         wr(12'h000, en << (k < 2 ? 1 : 2));
         host.xfer(1'b0, 12'h000, 32'h0, q, e);
         chk(q, en << (k < 2 ? 1 : 2));
         ru <= k == 0;
         rdn <= k == 1;
         pe <= k == 2;
         wait_cyc(30);
         chk(pin_n, k == 2 ? !en : 1);
         wait_cyc(40);
         chk(fet, en);
         chk(pin_n, !en);
         host.xfer(1'b0, 12'h008, 32'h0, q, e);
         chk(q[k + 2], en);
         ru <= 1'b0;
         rdn <= 1'b0;
         pe <= 1'b0;
         wait_cyc(50);
         chk(fet, 0);
         host.clr;
      end
      $display("test detect done");
      give_verdict;
   end
endmodule // tb_top
